// ---- logic/adcr_pkg.sv ----
package adcr_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int PD_ENTRY_US   = 10;
	localparam int PD_ENTRY_CYC  = (PD_ENTRY_US * 1000) / CLK_PERIOD_NS;
	localparam int NAP_ENTRY_NS  = 200;
	localparam int NAP_ENTRY_CYC = NAP_ENTRY_NS / CLK_PERIOD_NS;
	localparam int CONV_TIME_NS  = 1160;
	localparam int CONV_CYC_INT  = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0] CONV_CYC = CONV_CYC_INT[3:0];

	// ----------------------------------------------------------------
	// Result coding
	// ----------------------------------------------------------------
	localparam int          RES_W        = 16;
	localparam logic [15:0] SIGN_FLIP    = 16'h8000;
	localparam logic [15:0] ABORT_CODE   = 16'hff00;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [1:0]  TRIM_CONVS   = 2'h2;

	// ----------------------------------------------------------------
	// Conversion control states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF,
		ST_SAMPLE,
		ST_CONVERT,
		ST_WAIT,
		ST_NAP
	} adcr_state_t;

endpackage

// ---- logic/adcr_cdc_buf.sv ----
`timescale 1ns/1ps
module adcr_cdc_buf
	#(
		parameter int WIDTH  = 16,
		parameter int ADDR_W = 1
	)
	(
		// Reset
		input  wire logic              nrst,
		// Filling side
		input  wire logic              wr_clk,
		input  wire logic              wr_valid,
		output logic                   wr_ready,
		input  wire logic [WIDTH-1:0]  wr_data,
		// Draining side
		input  wire logic              rd_clk,
		output logic                   rd_valid,
		input  wire logic              rd_ready,
		output logic      [WIDTH-1:0]  rd_data
	);

	localparam int DEPTH = 1 << ADDR_W;
	// Gray pointer of a full buffer differs from the other side's in its top two bits
	localparam logic [ADDR_W:0] FULL_MASK = (ADDR_W+1)'(3 << (ADDR_W - 1));

	function automatic logic [ADDR_W:0] to_gray(input logic [ADDR_W:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];
	logic [ADDR_W:0]  wbin_reg;
	logic [ADDR_W:0]  rbin_reg;
	logic [ADDR_W:0]  wgray_reg;
	logic [ADDR_W:0]  rgray_reg;
	logic [ADDR_W:0]  rg_m_reg;
	logic [ADDR_W:0]  rg_s_reg;
	logic [ADDR_W:0]  wg_m_reg;
	logic [ADDR_W:0]  wg_s_reg;
	logic [ADDR_W:0]  wbin_next;
	logic [ADDR_W:0]  rbin_next;
	wire              do_wr;
	wire              do_rd;

	// Full when the write pointer leads by the whole depth
	assign wr_ready  = (wgray_reg != (rg_s_reg ^ FULL_MASK));
	assign rd_valid  = (rgray_reg != wg_s_reg);
	assign do_wr     = wr_valid & wr_ready;
	assign do_rd     = rd_valid & rd_ready;
	assign wbin_next = wbin_reg + {{ADDR_W{1'b0}}, do_wr};
	assign rbin_next = rbin_reg + {{ADDR_W{1'b0}}, do_rd};
	assign rd_data   = mem[rbin_reg[ADDR_W-1:0]];

	always_ff @(posedge wr_clk)
	begin
		if (do_wr)
			mem[wbin_reg[ADDR_W-1:0]] <= wr_data;
	end

	always_ff @(posedge wr_clk or negedge nrst)
	begin
		if (!nrst) begin
			wbin_reg  <= '0;
			wgray_reg <= '0;
			rg_m_reg  <= '0;
			rg_s_reg  <= '0;
		end else begin
			wbin_reg  <= wbin_next;
			wgray_reg <= to_gray(wbin_next);
			rg_m_reg  <= rgray_reg;
			rg_s_reg  <= rg_m_reg;
		end
	end

	always_ff @(posedge rd_clk or negedge nrst)
	begin
		if (!nrst) begin
			rbin_reg  <= '0;
			rgray_reg <= '0;
			wg_m_reg  <= '0;
			wg_s_reg  <= '0;
		end else begin
			rbin_reg  <= rbin_next;
			rgray_reg <= to_gray(rbin_next);
			wg_m_reg  <= wgray_reg;
			wg_s_reg  <= wg_m_reg;
		end
	end

endmodule

// ---- logic/adcr_top.sv ----
// Summary of operation
// - Result is straight binary with format pin low, two's complement with it high.
// - Coding follows only the present format pin level, no register.
// - Output word is replaced with the new result at busy falling; code buffers it then and loads it only while no frame is open.
// - Powerdown pin high enters full power-down.
// - In power-down the data output is released, within 10 us.
// - Powerdown pin low resumes operation with the data output driven.
// - First two conversions after resume load trim and are invalid.
// - Conversion ending with qualified start low enters nap within 200 ns.
// - Frame shows MSB at chip select fall, shifts on later rising edges.
// - A restarted frame abandons the old one and starts from the MSB.
// - Conversion end with qualified start high and no sample start request enters the wait state.
`timescale 1ns/1ps
module adcr_top
	import adcr_pkg::*;
	(
		// System clock and reset
		input  wire logic        sys_clk,
		input  wire logic        nrst,
		// Control pins
		input  wire logic        convert_start_pin,
		input  wire logic        powerdown_pin,
		input  wire logic        output_format_select,
		// Converter core code, straight binary
		input  wire logic [15:0] sar_code,
		// Serial link
		input  wire logic        sclk,
		input  wire logic        cs_n_pin,
		input  wire logic        frame_sync_pin,
		output logic             sdo,
		output logic             sdo_oe_n,
		// Status
		output logic             busy,
		output logic             nap_active,
		output logic             powered_down,
		output logic             trim_invalid,
		output logic             result_stall
	);

	// ----------------------------------------------------------------
	// Pin synchronisers, system domain
	// ----------------------------------------------------------------
	logic        conv_m_reg;
	logic        conv_s_reg;
	logic        conv_q_reg;
	logic        pd_m_reg;
	logic        pd_s_reg;
	logic        fmt_m_reg;
	logic        fmt_s_reg;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst) begin
			conv_m_reg <= 1'b1;
			conv_s_reg <= 1'b1;
			conv_q_reg <= 1'b1;
			pd_m_reg   <= 1'b0;
			pd_s_reg   <= 1'b0;
			fmt_m_reg  <= 1'b0;
			fmt_s_reg  <= 1'b0;
		end else begin
			conv_m_reg <= convert_start_pin;
			conv_s_reg <= conv_m_reg;
			conv_q_reg <= conv_s_reg;
			pd_m_reg   <= powerdown_pin;
			pd_s_reg   <= pd_m_reg;
			fmt_m_reg  <= output_format_select;
			fmt_s_reg  <= fmt_m_reg;
		end
	end

	// ----------------------------------------------------------------
	// Conversion control
	// ----------------------------------------------------------------
	adcr_state_t state_reg;
	adcr_state_t state_next;
	logic [3:0]  conv_cnt_reg;
	logic        sample_req_reg;
	logic [1:0]  trim_cnt_reg;
	logic        push_valid_reg;
	logic [15:0] push_data_reg;
	logic        push_ready;
	logic        busy_reg;
	logic        nap_reg;
	logic        pd_out_reg;
	logic        trim_inv_reg;

	wire         qualified_convert_start = conv_s_reg;
	wire         start_fall   = conv_q_reg & ~conv_s_reg;
	wire         sample_start = ~conv_q_reg & conv_s_reg;
	wire         in_conv      = (state_reg == ST_CONVERT);
	wire         eoc          = in_conv & (conv_cnt_reg == 4'h0);
	wire         abort        = in_conv & start_fall & ~eoc;
	wire         can_start    = (state_reg == ST_SAMPLE) & start_fall & ~push_valid_reg;
	wire [15:0]  coded        = fmt_s_reg ? (sar_code ^ SIGN_FLIP) : sar_code;
	wire         trim_phase   = (trim_cnt_reg < TRIM_CONVS);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF:     state_next = ST_WAIT;
			ST_SAMPLE:  if (can_start) state_next = ST_CONVERT;
			ST_CONVERT:
				if (abort)
					state_next = ST_WAIT;
				else if (eoc && !qualified_convert_start)
					state_next = ST_NAP;
				else if (eoc && (sample_req_reg || sample_start))
					state_next = ST_SAMPLE;
				else if (eoc)
					state_next = ST_WAIT;
			ST_WAIT:    if (sample_start) state_next = ST_SAMPLE;
			ST_NAP:     if (sample_start) state_next = ST_SAMPLE;
			default:    state_next = ST_WAIT;
		endcase
		if (pd_s_reg)
			state_next = ST_OFF;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst) begin
			state_reg      <= ST_WAIT;
			conv_cnt_reg   <= 4'h0;
			sample_req_reg <= 1'b0;
		end else begin
			state_reg      <= state_next;
			conv_cnt_reg   <= can_start ? CONV_CYC - 4'h1 : conv_cnt_reg - {3'h0, |conv_cnt_reg};
			sample_req_reg <= in_conv & (sample_req_reg | sample_start);
		end
	end

	// Trim counter restarts on every stay in power-down
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst) begin
			trim_cnt_reg <= 2'h0;
			trim_inv_reg <= 1'b1;
		end else if (state_reg == ST_OFF) begin
			trim_cnt_reg <= 2'h0;
			trim_inv_reg <= 1'b1;
		end else if (eoc) begin
			trim_cnt_reg <= trim_cnt_reg + {1'b0, trim_phase};
			trim_inv_reg <= trim_phase;
		end
	end

	// New word held until the buffer takes it; starts stall meanwhile
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst) begin
			push_valid_reg <= 1'b0;
			push_data_reg  <= RESULT_RESET;
		end else if (eoc || abort) begin
			push_valid_reg <= 1'b1;
			push_data_reg  <= abort ? ABORT_CODE : coded;
		end else if (push_ready) begin
			push_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst) begin
			busy_reg   <= 1'b0;
			nap_reg    <= 1'b0;
			pd_out_reg <= 1'b1;
		end else begin
			busy_reg   <= (state_next == ST_CONVERT);
			nap_reg    <= (state_next == ST_NAP);
			pd_out_reg <= (state_next == ST_OFF);
		end
	end

	assign busy         = busy_reg;
	assign nap_active   = nap_reg;
	assign powered_down = pd_out_reg;
	assign sdo_oe_n     = pd_out_reg;
	assign trim_invalid = trim_inv_reg;
	assign result_stall = push_valid_reg;

	// ----------------------------------------------------------------
	// Word crossing into the link domain
	// ----------------------------------------------------------------
	logic        rd_valid;
	logic        rd_ready;
	logic [15:0] rd_data;

	adcr_cdc_buf #(.WIDTH(RES_W), .ADDR_W(1)) u_buf
	(
		.nrst     (nrst),
		.wr_clk   (sys_clk),
		.wr_valid (push_valid_reg),
		.wr_ready (push_ready),
		.wr_data  (push_data_reg),
		.rd_clk   (sclk),
		.rd_valid (rd_valid),
		.rd_ready (rd_ready),
		.rd_data  (rd_data)
	);

	// ----------------------------------------------------------------
	// Serial link, sclk domain
	// ----------------------------------------------------------------
	logic        cs_m_reg;
	logic        cs_s_reg;
	logic        fs_m_reg;
	logic        fs_s_reg;
	logic        fs_q_reg;
	logic        first_reg;
	logic [15:0] word_reg;
	logic [15:0] shreg_reg;

	wire         frame_idle = cs_s_reg | (fs_s_reg & ~fs_q_reg);
	wire [15:0]  load_word  = rd_valid ? rd_data : word_reg;

	assign rd_ready = frame_idle;
	assign sdo      = shreg_reg[15];

	always_ff @(posedge sclk or negedge nrst)
	begin
		if (!nrst) begin
			cs_m_reg <= 1'b1;
			cs_s_reg <= 1'b1;
			fs_m_reg <= 1'b1;
			fs_s_reg <= 1'b1;
			fs_q_reg <= 1'b1;
		end else begin
			cs_m_reg <= cs_n_pin;
			cs_s_reg <= cs_m_reg;
			fs_m_reg <= frame_sync_pin;
			fs_s_reg <= fs_m_reg;
			fs_q_reg <= fs_s_reg;
		end
	end

	always_ff @(posedge sclk or negedge nrst)
	begin
		if (!nrst) begin
			first_reg <= 1'b1;
			word_reg  <= RESULT_RESET;
			shreg_reg <= RESULT_RESET;
		end else if (frame_idle) begin
			first_reg <= 1'b1;
			word_reg  <= load_word;
			shreg_reg <= load_word;
		end else if (first_reg) begin
			first_reg <= 1'b0;
		end else begin
			shreg_reg <= {shreg_reg[14:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_straight_code: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !abort && !fmt_s_reg) |=> (push_data_reg == $past(sar_code)))
		else $error("straight binary code wrong");
	a_twos_code: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !abort && fmt_s_reg) |=> (push_data_reg == ($past(sar_code) ^ 16'h8000)))
		else $error("twos complement code wrong");
	a_word_update: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !pd_s_reg) |=> push_valid_reg && !busy_reg)
		else $error("result not offered at busy fall");
	a_pd_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(pd_s_reg) |-> ##1 (sdo_oe_n && powered_down))
		else $error("power-down not entered");
	a_pd_resume: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(pd_s_reg) |-> ##[1:2] !sdo_oe_n)
		else $error("output not driven after resume");
	a_trim_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !pd_s_reg && trim_cnt_reg < 2'h2) |=> trim_inv_reg)
		else $error("trim conversion not flagged");
	a_trim_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !pd_s_reg && trim_cnt_reg == 2'h2) |=> !trim_inv_reg)
		else $error("valid conversion flagged");
	a_nap_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !abort && !pd_s_reg && !conv_s_reg) |-> ##[1:2] (nap_reg && !sdo_oe_n))
		else $error("nap not entered");
	a_wait_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
		(eoc && !abort && !pd_s_reg && conv_s_reg && !sample_req_reg && !sample_start)
		|=> state_reg == ST_WAIT)
		else $error("wait state not entered");
	a_pd_ignore: assert property (@(posedge sys_clk) disable iff (!nrst)
		(state_reg == ST_OFF && pd_s_reg) |=> (state_reg == ST_OFF && !busy_reg))
		else $error("activity during power-down");
	a_frame_msb: assert property (@(posedge sclk) disable iff (!nrst)
		(frame_idle && !rd_valid) |=> shreg_reg == $past(word_reg))
		else $error("frame not restarted from MSB");

	c_conversion: cover property (@(posedge sys_clk) disable iff (!nrst) eoc);
	c_nap: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(nap_reg));
	c_powerdown: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(pd_out_reg));
	c_abort: cover property (@(posedge sys_clk) disable iff (!nrst) abort);

endmodule

// ---- sim/adcr_host_model.sv ----
`timescale 1ns/1ps
module adcr_host_model
	import adcr_pkg::*;
	(
		// Clocks
		input  wire logic        sys_clk,
		input  wire logic        sclk,
		// Device pins
		output logic             convert_start_pin,
		output logic             cs_n_pin,
		output logic             frame_sync_pin,
		input  wire logic        sdo,
		input  wire logic        busy,
		// Captured word
		output logic [15:0]      rd_word,
		output logic             rd_done
	);

	initial
	begin
		convert_start_pin = 1'b0;
		cs_n_pin = 1'b1;
		frame_sync_pin = 1'b1;
		rd_word = 16'h0000;
		rd_done = 1'b0;
	end

	// ----------------------------------------------------------------
	// Conversion: mode 0 ends in nap, 1 requests back-to-back, 2 aborts
	// ----------------------------------------------------------------
	task automatic convert(input int mode);
		int n;
		@(negedge sys_clk);
		convert_start_pin <= 1'b1;
		repeat (6) @(negedge sys_clk);
		convert_start_pin <= 1'b0;
		for (n = 0; n < 20 && busy !== 1'b1; n++)
			@(negedge sys_clk);
		if (mode != 0)
		begin
			@(negedge sys_clk);
			convert_start_pin <= 1'b1;
		end
		if (mode == 2)
		begin
			repeat (2) @(negedge sys_clk);
			convert_start_pin <= 1'b0;
		end
		for (n = 0; n < 30 && busy !== 1'b0; n++)
			@(negedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// Read frame of nb bits; a shorter frame is abandoned unreported
	// ----------------------------------------------------------------
	task automatic read(input int nb);
		int i;
		@(negedge sclk);
		cs_n_pin <= 1'b1;
		// Idle long enough for a stalled word to cross and load
		repeat (16) @(negedge sclk);
		cs_n_pin <= 1'b0;
		repeat (3) @(posedge sclk);
		for (i = 15; i > 15 - nb; i--)
		begin
			@(negedge sclk);
			rd_word[i] = sdo;
		end
		if (nb == 16)
		begin
			rd_done <= 1'b1;
			@(negedge sclk);
			rd_done <= 1'b0;
		end
		else
		begin
			// Short frame also restarted by a frame sync rise
			frame_sync_pin <= 1'b0;
			repeat (3) @(negedge sclk);
			frame_sync_pin <= 1'b1;
			repeat (3) @(negedge sclk);
		end
		cs_n_pin <= 1'b1;
	endtask

	// Keeps a frame open so the link stops draining
	task automatic hold();
		@(negedge sclk);
		cs_n_pin <= 1'b0;
	endtask

endmodule

// ---- sim/adcr_top_tb.sv ----
`timescale 1ns/1ps
module adcr_top_tb
	import adcr_pkg::*;
	;

	localparam logic [15:0] EDGE_CODES [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};

	logic        sys_clk;
	logic        sclk;
	logic        nrst;
	logic        powerdown_pin;
	logic        output_format_select;
	logic [15:0] sar_code;
	logic [15:0] code;
	logic [31:0] lfsr;
	logic        pd_watch;
	wire         convert_start_pin;
	wire         cs_n_pin;
	wire         frame_sync_pin;
	wire         sdo;
	wire         sdo_oe_n;
	wire         busy;
	wire         nap_active;
	wire         powered_down;
	wire         trim_invalid;
	wire         result_stall;
	wire  [15:0] rd_word;
	wire         rd_done;
	logic [15:0] exp_q[$];
	int          num_errors;
	int          num_checks;
	int          cyc;
	int          i;

	adcr_top adcr_top_i (
		.sys_clk              (sys_clk),
		.nrst                 (nrst),
		.convert_start_pin    (convert_start_pin),
		.powerdown_pin        (powerdown_pin),
		.output_format_select (output_format_select),
		.sar_code             (sar_code),
		.sclk                 (sclk),
		.cs_n_pin             (cs_n_pin),
		.frame_sync_pin       (frame_sync_pin),
		.sdo                  (sdo),
		.sdo_oe_n             (sdo_oe_n),
		.busy                 (busy),
		.nap_active           (nap_active),
		.powered_down         (powered_down),
		.trim_invalid         (trim_invalid),
		.result_stall         (result_stall)
	);

	adcr_host_model adcr_host_model_i (
		.sys_clk           (sys_clk),
		.sclk              (sclk),
		.convert_start_pin (convert_start_pin),
		.cs_n_pin          (cs_n_pin),
		.frame_sync_pin    (frame_sync_pin),
		.sdo               (sdo),
		.busy              (busy),
		.rd_word           (rd_word),
		.rd_done           (rd_done)
	);

	// ----------------------------------------------------------------
	// Clocks, timeout and helpers
	// ----------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial
	begin
		sclk = 1'b0;
		#7;
		forever #32 sclk = ~sclk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end

	// Each finished frame is matched against the oldest noted word
	always @(posedge rd_done)
	begin
		if (exp_q.size() == 0)
			chk(rd_word, ~rd_word);
		else
			chk(rd_word, exp_q.pop_front());
	end

	// No conversion may run while powered down
	always @(negedge sys_clk)
		if (pd_watch && busy !== 1'b0)
			chk(busy, 1'b0);

	task automatic conv_word(input logic [15:0] c, input logic fmt, input int mode,
		input logic inval);
		@(negedge sys_clk);
		sar_code = c;
		output_format_select = fmt;
		adcr_host_model_i.convert(mode);
		chk(busy, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk(nap_active, mode == 0);
		chk(trim_invalid, inval);
		exp_q.push_back(mode == 2 ? ABORT_CODE : (fmt ? c ^ SIGN_FLIP : c));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		nrst = 1'b0;
		powerdown_pin = 1'b0;
		output_format_select = 1'b0;
		sar_code = 16'h0000;
		lfsr = 32'h6fae;
		pd_watch = 1'b0;
		num_errors = 0;
		num_checks = 0;
		cyc = 0;
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk(sdo_oe_n, 1'b0);
		chk(trim_invalid, 1'b1);
		exp_q.push_back(RESULT_RESET);
		adcr_host_model_i.read(16);
		for (i = 0; i < 8; i++)
		begin
			lfsr = lfsr_next(lfsr);
			code = (i < 4) ? EDGE_CODES[i] : lfsr[15:0];
			conv_word(code, i[0], (i % 3 == 2) ? 1 : 0, i < 2);
			if (i == 3)
				adcr_host_model_i.read(5);
			adcr_host_model_i.read(16);
		end
		conv_word(lfsr[31:16], 1'b0, 2, 1'b0);
		adcr_host_model_i.read(16);
		// Fill the buffer with the link held busy, then drain it
		adcr_host_model_i.hold();
		for (i = 0; i < 3; i++)
			conv_word(16'h1230 + 16'(i), 1'b0, 0, 1'b0);
		void'(exp_q.pop_front());
		void'(exp_q.pop_front());
		repeat (20) @(negedge sys_clk);
		chk(result_stall, 1'b1);
		adcr_host_model_i.read(16);
		chk(result_stall, 1'b0);
		// Power-down, ignored activity, resume with trim loads
		powerdown_pin = 1'b1;
		repeat (PD_ENTRY_CYC) @(negedge sys_clk);
		chk(sdo_oe_n, 1'b1);
		chk(powered_down, 1'b1);
		pd_watch = 1'b1;
		adcr_host_model_i.convert(0);
		pd_watch = 1'b0;
		powerdown_pin = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk(sdo_oe_n, 1'b0);
		for (i = 0; i < 3; i++)
		begin
			lfsr = lfsr_next(lfsr);
			conv_word(lfsr[15:0], 1'b1, 0, i < 2);
			adcr_host_model_i.read(16);
		end
		repeat (10) @(negedge sys_clk);
		chk(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end

endmodule
